// File: core/fer_regs.svh
/*
 register map, field positions and reset values of the floating-point error reporting unit.
 assumes a 32-bit axi4-lite register bus with one register per aligned word.
*/
`ifndef FER_REGS_SVH
`define FER_REGS_SVH

`define FER_ADDR_W 4
`define FER_OFS_CTRL 4'h0
`define FER_OFS_STATUS 4'h4
`define FER_OFS_INT_STATUS 4'h8
`define FER_OFS_INT_MASK 4'hC

`define FER_NUM_EXC 6
`define FER_NUM_EV 4
`define FER_CTRL_MASK_LSB 0
`define FER_CTRL_NE_BIT 8
`define FER_CTRL_DEFER_BIT 9
`define FER_CTRL_W 10
`define FER_CTRL_RESET 10'h03F

`define FER_ST_ERR_BIT 6
`define FER_ST_FROZEN_BIT 7
`define FER_ST_SIMD_LSB 8

`define FER_EV_ERR 0
`define FER_EV_FREEZE 1
`define FER_EV_SIMD 2
`define FER_EV_IGNORED 3

`define FER_RESP_OKAY 2'b00
`define FER_RESP_SLVERR 2'b10

`endif

// File: core/fer_pkg.sv
/*
 types of the floating-point error reporting unit.
 assumes fer_regs.svh supplies the widths.
*/
`default_nettype none
`include "fer_regs.svh"

package fer_pkg;

    // instruction classes as the core presents them at issue
    typedef enum logic [2:0] {
        FER_KIND_WAIT,
        FER_KIND_NOWAIT,
        FER_KIND_CLEAR,
        FER_KIND_INIT,
        FER_KIND_SAVE,
        FER_KIND_RESTORE,
        FER_KIND_LOADENV
    } fer_kind_t;

    typedef struct packed {
        logic valid;
        fer_kind_t kind;
        logic [`FER_NUM_EXC-1:0] load_flags;
    } fer_issue_t;

    typedef struct packed {
        logic valid;
        logic simd;
        logic [`FER_NUM_EXC-1:0] flags;
    } fer_exc_t;

    typedef enum logic {
        FER_RUN,
        FER_FROZEN
    } fer_state_t;

endpackage : fer_pkg

`default_nettype wire

// File: core/fer_top.sv
/*
 floating-point error reporting unit: sticky exception flags, numeric-error pin, freeze control,
 event interrupt and an axi4-lite register slave.
 assumes the core presents issue and exception reports on sys_clk; pins are asynchronous.
*/
// The implementer's own choices: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fer_regs.svh"

// Operation
// RULE1 - exception flags are sticky, accumulating until explicitly cleared
// RULE2 - only clear, reinitialise, save, restore or load-environment alter the flags
// RULE3 - unmasked compatibility-mode error is delivered through external interrupt controller and irq
// RULE4 - error pin asserts at detection or at next waiting instruction, per setting
// RULE5 - pending unmasked exception freezes next waiting instruction unless ignored or no-wait
// RULE6 - frozen core stays frozen until an external interrupt arrives
// RULE7 - with the error interrupt disabled, freeze lasts until another interrupt
// RULE8 - compatibility mode with ignore input active disregards the exception and continues
// RULE9 - error line to the host signals unmasked exceptions
// RULE10 - waiting instruction with flags still active raises the error again
// RULE11 - handler clears or disables active flags before return or further waiting instructions
// RULE12 - error pin deasserts once the flags are cleared
// RULE13 - handler should clear the controller request before clearing the unit's error
// RULE14 - masked exceptions set flags only, with no external indication
// RULE15 - simd exceptions never drive the error pin and ignore the ignore input
// RULE16 - error pin holds while any unmasked flag is set, inactive from reset; the code keeps the pin inactive whenever the ctrl NE bit is set
module fer_top
    import fer_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // core side
    input wire fer_issue_t issue,
    input wire fer_exc_t exc,
    output logic freeze_out,
    output logic native_fault_out,
    // pins
    input wire logic ignore_numeric_error_in_n,
    input wire logic maskable_irq_in,
    output logic numeric_error_out_n,
    output logic irq,
    // axi4-lite slave
    input wire logic [`FER_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`FER_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    localparam int NX = `FER_NUM_EXC;
    localparam int NE = `FER_NUM_EV;

    // pin synchronisers
    logic ign_meta;
    logic ign_sync;
    logic irq_meta;
    logic irq_sync;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ign_meta <= 1'b1;
            ign_sync <= 1'b1;
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end
        else
        begin
            ign_meta <= ignore_numeric_error_in_n;
            ign_sync <= ign_meta;
            irq_meta <= maskable_irq_in;
            irq_sync <= irq_meta;
        end
    end

    // axi write and read state
    logic aw_got;
    logic w_got;
    logic [`FER_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wr_fire;
    logic next_aw_got;
    logic next_w_got;
    logic [`FER_ADDR_W-1:0] next_waddr;
    logic [31:0] next_wdata;
    logic [3:0] next_wstrb;
    logic next_wr_fire;
    logic next_awready;
    logic next_wready;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_arready;
    logic next_rvalid;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;

    // unit state
    logic [`FER_CTRL_W-1:0] ctrl;
    logic [NX-1:0] flags;
    logic [NX-1:0] simd_flags;
    logic [NE-1:0] int_status;
    logic [NE-1:0] int_mask;
    logic armed;
    logic err_prev;
    fer_state_t state;
    logic [`FER_CTRL_W-1:0] next_ctrl;
    logic [NX-1:0] next_flags;
    logic [NX-1:0] next_simd_flags;
    logic [NE-1:0] next_int_status;
    logic [NE-1:0] next_int_mask;
    logic next_armed;
    logic next_err_prev;
    fer_state_t next_state;
    logic next_freeze;
    logic next_native_fault;
    logic next_error_n;
    logic next_irq;

    logic [31:0] status_word;
    logic pending;
    logic err_active;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val, input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = val[b*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[NX-1:0] = flags;
        status_word[`FER_ST_ERR_BIT] = ~numeric_error_out_n;
        status_word[`FER_ST_FROZEN_BIT] = freeze_out;
        status_word[`FER_ST_SIMD_LSB +: NX] = simd_flags;
    end

    // axi channels: one write and one read under way at most
    always_comb
    begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_waddr = waddr;
        next_wdata = wdata;
        next_wstrb = wstrb;
        next_wr_fire = 1'b0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = s_axi_arready;
        next_rvalid = s_axi_rvalid;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_aw_got = 1'b1;
            next_waddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_w_got = 1'b1;
            next_wdata = s_axi_wdata;
            next_wstrb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
        begin
            next_bvalid = 1'b0;
        end
        if (aw_got && w_got && !s_axi_bvalid)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_wr_fire = 1'b1;
            next_bvalid = 1'b1;
            next_bresp = (waddr == `FER_OFS_CTRL || waddr == `FER_OFS_INT_STATUS || waddr == `FER_OFS_INT_MASK)
                ? `FER_RESP_OKAY : `FER_RESP_SLVERR;
        end
        next_awready = !next_aw_got && !next_bvalid && !next_wr_fire;
        next_wready = !next_w_got && !next_bvalid && !next_wr_fire;
        if (s_axi_arvalid && s_axi_arready)
        begin
            next_arready = 1'b0;
            next_rvalid = 1'b1;
            next_rresp = `FER_RESP_OKAY;
            case (s_axi_araddr)
                `FER_OFS_CTRL: next_rdata = {{(32-`FER_CTRL_W){1'b0}}, ctrl};
                `FER_OFS_STATUS: next_rdata = status_word;
                `FER_OFS_INT_STATUS: next_rdata = {{(32-NE){1'b0}}, int_status};
                `FER_OFS_INT_MASK: next_rdata = {{(32-NE){1'b0}}, int_mask};
                default:
                begin
                    next_rdata = 32'h0000_0000;
                    next_rresp = `FER_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            next_rvalid = 1'b0;
            next_arready = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            waddr <= '0;
            wdata <= 32'h0000_0000;
            wstrb <= 4'h0;
            wr_fire <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `FER_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `FER_RESP_OKAY;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            waddr <= next_waddr;
            wdata <= next_wdata;
            wstrb <= next_wstrb;
            wr_fire <= next_wr_fire;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready || (!s_axi_arready && !s_axi_rvalid && !next_rvalid);
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end

    // error reporting core
    always_comb
    begin
        logic ignore_active;
        logic waits;
        logic stalls;
        logic clear_ev;
        logic [NE-1:0] ev;
        logic [31:0] w1c;
        ignore_active = !ign_sync;
        // masked exceptions only keep their flag
        pending = |(flags & ~ctrl[`FER_CTRL_MASK_LSB +: NX]); // [RULE14]
        waits = issue.valid && (issue.kind == FER_KIND_WAIT || issue.kind == FER_KIND_RESTORE
            || issue.kind == FER_KIND_LOADENV);
        stalls = waits && pending && state == FER_RUN;
        ev = '0;
        next_state = state;
        next_native_fault = 1'b0;
        next_ctrl = ctrl;
        next_int_mask = int_mask;
        next_flags = flags;
        next_simd_flags = simd_flags;
        clear_ev = 1'b0;
        case (state)
            FER_RUN:
            begin
                if (stalls && ctrl[`FER_CTRL_NE_BIT])
                begin
                    next_native_fault = 1'b1;
                end
                else if (stalls && ignore_active)
                begin
                    ev[`FER_EV_IGNORED] = 1'b1; // [RULE8]
                end
                else if (stalls)
                begin
                    next_state = FER_FROZEN; // [RULE5] [RULE10]
                    ev[`FER_EV_FREEZE] = 1'b1;
                end
            end
            FER_FROZEN:
            begin
                // any taken interrupt releases, the error one or another [RULE6] [RULE7]
                if (irq_sync || ignore_active)
                begin
                    next_state = FER_RUN; // [RULE8]
                end
            end
            default: next_state = FER_RUN;
        endcase
        // a stalled instruction does not execute, so it cannot touch the flags
        if (issue.valid && !stalls && state == FER_RUN)
        begin
            case (issue.kind)
                FER_KIND_CLEAR, FER_KIND_INIT, FER_KIND_SAVE:
                begin
                    next_flags = '0; // [RULE2]
                    clear_ev = 1'b1;
                end
                FER_KIND_RESTORE, FER_KIND_LOADENV: next_flags = issue.load_flags; // [RULE2]
                default: next_flags = flags;
            endcase
        end
        // set wins over a clear in the same cycle
        if (exc.valid && exc.simd)
        begin
            next_simd_flags = simd_flags | exc.flags; // [RULE15]
            ev[`FER_EV_SIMD] = 1'b1;
        end
        else if (exc.valid)
        begin
            next_flags = next_flags | exc.flags; // [RULE1]
        end
        // deferred reporting waits for the next issued instruction that is not a no-wait one
        next_armed = pending && (armed || (issue.valid && issue.kind != FER_KIND_NOWAIT)) && !clear_ev; // [RULE4]
        err_active = pending && !ctrl[`FER_CTRL_NE_BIT] && (!ctrl[`FER_CTRL_DEFER_BIT] || armed); // [RULE4] [RULE16]
        next_error_n = !err_active; // [RULE3] [RULE9] [RULE12]
        next_err_prev = err_active;
        ev[`FER_EV_ERR] = err_active && !err_prev;
        w1c = 32'h0000_0000;
        if (wr_fire && waddr == `FER_OFS_CTRL)
        begin
            next_ctrl = `FER_CTRL_W'(merge({{(32-`FER_CTRL_W){1'b0}}, ctrl}, wdata, wstrb));
        end
        if (wr_fire && waddr == `FER_OFS_INT_MASK)
        begin
            next_int_mask = NE'(merge({{(32-NE){1'b0}}, int_mask}, wdata, wstrb));
        end
        if (wr_fire && waddr == `FER_OFS_INT_STATUS)
        begin
            w1c = merge(32'h0000_0000, wdata, wstrb);
        end
        next_int_status = (int_status & ~w1c[NE-1:0]) | ev;
        next_irq = |(next_int_status & next_int_mask);
        next_freeze = next_state == FER_FROZEN;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl <= `FER_CTRL_RESET;
            flags <= '0;
            simd_flags <= '0;
            int_status <= '0;
            int_mask <= '0;
            armed <= 1'b0;
            err_prev <= 1'b0;
            state <= FER_RUN;
            freeze_out <= 1'b0;
            native_fault_out <= 1'b0;
            numeric_error_out_n <= 1'b1;
            irq <= 1'b0;
        end
        else
        begin
            ctrl <= next_ctrl;
            flags <= next_flags;
            simd_flags <= next_simd_flags;
            int_status <= next_int_status;
            int_mask <= next_int_mask;
            armed <= next_armed;
            err_prev <= next_err_prev;
            state <= next_state;
            freeze_out <= next_freeze;
            native_fault_out <= next_native_fault;
            numeric_error_out_n <= next_error_n;
            irq <= next_irq;
        end
    end

endmodule : fer_top

`default_nettype wire

// File: testbench/fer_top_monitor.sv
/*
 checker of the error unit's pins and read answers.
 assumes a bind into fer_top.
*/
`timescale 1ns/1ns
`default_nettype none
module fer_top_monitor
    import fer_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // core and pins
    input wire fer_issue_t issue,
    input wire fer_exc_t exc,
    input wire logic freeze_out,
    input wire logic numeric_error_out_n,
    input wire logic irq,
    input wire logic maskable_irq_in,
    input wire logic ignore_numeric_error_in_n,
    // bus
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [3:0] quiet;
    logic [3:0] ign;
    logic hard;
    logic [3:0] next_quiet;
    logic [3:0] next_ign;
    logic next_hard;
    logic stall;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    assign stall = issue.valid && (issue.kind inside {FER_KIND_WAIT, FER_KIND_RESTORE, FER_KIND_LOADENV});
    // counters saturate, so a long spell never wraps back under the threshold
    always_comb
    begin
        next_quiet = (maskable_irq_in || !ignore_numeric_error_in_n) ? 4'h0 : quiet + {3'h0, quiet != 4'hf};
        next_ign = ignore_numeric_error_in_n ? 4'h0 : ign + {3'h0, ign != 4'hf};
        next_hard = hard || (exc.valid && !exc.simd) || issue.valid;
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            quiet <= 4'h0;
            ign <= 4'h0;
            hard <= 1'b0;
        end
        else
        begin
            quiet <= next_quiet;
            ign <= next_ign;
            hard <= next_hard;
        end
    end
    AST_RESET_IDLE: assert property ($fell(rst) |-> numeric_error_out_n && !freeze_out && !irq)
        else $error("outputs busy right after reset");
    AST_FREEZE_CAUSE: assert property ($rose(freeze_out) |-> $past(stall) || $past(stall, 2))
        else $error("freeze without a waiting instruction");
    // pin synchronisers lag, so only a long quiet spell is held against the freeze
    AST_FREEZE_HOLD: assert property (freeze_out && quiet > 4'h6 |=> freeze_out)
        else $error("freeze dropped with no interrupt");
    AST_FREEZE_END: assert property (freeze_out && maskable_irq_in |-> ##[1:6] !freeze_out)
        else $error("freeze kept after interrupt");
    AST_IGNORE_RUN: assert property (ign > 4'h6 |-> !freeze_out)
        else $error("frozen while error ignored");
    AST_CLEAR_PIN: assert property (issue.valid && issue.kind == FER_KIND_CLEAR && !freeze_out && !exc.valid
        ##1 !exc.valid |=> numeric_error_out_n)
        else $error("error pin kept after clear");
    AST_SIMD_QUIET: assert property (!hard |-> numeric_error_out_n)
        else $error("error pin without a plain exception");
    AST_R_ONCE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answered twice");
endmodule : fer_top_monitor
bind fer_top fer_top_monitor i_fer_top_monitor (.sys_clk(sys_clk), .rst(rst), .issue(issue), .exc(exc),
    .freeze_out(freeze_out), .numeric_error_out_n(numeric_error_out_n), .irq(irq),
    .maskable_irq_in(maskable_irq_in), .ignore_numeric_error_in_n(ignore_numeric_error_in_n),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire

// File: testbench/fer_glue.sv
/*
 glue and interrupt controller model between the error pin and the irq pin.
 assumes the bench plays the handler on line_enable, port_clear and other_irq.
*/
`timescale 1ns/1ns
`default_nettype none
module fer_glue
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // pins
    input wire logic numeric_error_out_n,
    output logic maskable_irq_in,
    // handler side
    input wire logic line_enable,
    input wire logic port_clear,
    input wire logic other_irq
);
    logic pin_q;
    logic req;
    logic next_req;
    // edge latched like a controller input; a port write drops it
    always_comb
    begin
        next_req = req || (pin_q && !numeric_error_out_n);
        if (port_clear)
            next_req = 1'b0;
    end
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pin_q <= 1'b1;
            req <= 1'b0;
        end
        else
        begin
            pin_q <= numeric_error_out_n;
            req <= next_req;
        end
    end
    assign maskable_irq_in = (req && line_enable) || other_irq;
endmodule : fer_glue
`default_nettype wire

// File: testbench/fer_top_bench.sv
/*
 self-checking bench of the error unit with the glue model on its pins.
 assumes fer_top, fer_glue and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "fer_regs.svh"
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin n_fail++; $display("unexpected %s: expected %h, seen %h", nm, e, s); end end
module fer_top_bench
    import fer_pkg::*;
();
    logic sys_clk, rst, freeze_out, ign_n, irq_in, err_n, irq, en, clr, other, nf;
    fer_issue_t issue;
    fer_exc_t exc;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0] bresp, rresp;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int seed, n_fail, checks, i, flags, ist, f;
    fer_kind_t ks[8] = '{FER_KIND_RESTORE, FER_KIND_NOWAIT, FER_KIND_SAVE, FER_KIND_LOADENV,
        FER_KIND_WAIT, FER_KIND_INIT, FER_KIND_LOADENV, FER_KIND_CLEAR};
    fer_top i_fer_top (.sys_clk(sys_clk), .rst(rst), .issue(issue), .exc(exc), .freeze_out(freeze_out),
        .native_fault_out(nf), .ignore_numeric_error_in_n(ign_n), .maskable_irq_in(irq_in),
        .numeric_error_out_n(err_n), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    fer_glue i_fer_glue (.sys_clk(sys_clk), .rst(rst), .numeric_error_out_n(err_n), .maskable_irq_in(irq_in),
        .line_enable(en), .port_clear(clr), .other_irq(other));
    initial
    begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    task automatic conclude();
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask : conclude
    task automatic cyc(input int n);
        begin
            repeat (n) @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask : cyc
    // handshakes are judged at the falling edge, where registered readies are settled
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] v, output logic [31:0] r);
        int n;
        logic ah = 1'b0;
        logic wh = 1'b0;
        logic bh = 1'b0;
        logic rh = 1'b0;
        begin
            @(posedge sys_clk);
            awaddr <= a;
            araddr <= a;
            wdata <= v;
            awvalid <= w;
            wvalid <= w;
            bready <= w;
            arvalid <= !w;
            rready <= !w;
            for (n = 0; n < 100 && !(bh || rh); n++)
            begin
                @(negedge sys_clk);
                ah = (awvalid && awready) || (arvalid && arready);
                wh = wvalid && wready;
                bh = bvalid && bready;
                rh = rvalid && rready;
                r = w ? {30'h0, bresp} : rdata;
                @(posedge sys_clk);
                awvalid <= awvalid && !ah;
                arvalid <= arvalid && !ah;
                wvalid <= wvalid && !wh;
                bready <= bready && !bh;
                rready <= rready && !rh;
            end
            if (!(bh || rh))
            begin
                n_fail++;
                conclude();
            end
        end
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
        begin
            bus(1'b1, a, v, d);
            `CHK("bresp", er, d[1:0])
        end
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        begin
            bus(1'b0, a, 32'h0, d);
            `CHK(nm, e, d & m)
        end
    endtask : rd
    task automatic core(input logic ie, input fer_kind_t k, input logic s, input logic [5:0] fl);
        begin
            @(posedge sys_clk);
            issue <= '{ie, k, fl};
            exc <= '{!ie, s, fl};
            @(posedge sys_clk);
            issue <= '0;
            exc <= '0;
        end
    endtask : core
    task automatic pulse_other();
        begin
            @(posedge sys_clk);
            other <= 1'b1;
            @(posedge sys_clk);
            other <= 1'b0;
        end
    endtask : pulse_other
    initial
    begin
        seed = 54;
        n_fail = 0;
        checks = 0;
        flags = 0;
        rst = 1'b1;
        {issue, exc, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        {en, clr, other} = 3'h0;
        ign_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        rd(4'h0, 32'hffff_ffff, 32'h0000_003f, "ctrl");
        rd(4'hc, 32'hffff_ffff, 32'h0000_0000, "int_mask");
        rd(4'h4, 32'hffff_ffff, 32'h0000_0000, "status");
        wr(4'h4, 32'h0000_0001, 2'b10);
        wr(4'hc, 32'h0000_000f, 2'b00);
        core(1'b0, FER_KIND_WAIT, 1'b1, 6'h2a);
        cyc(3);
        rd(4'h4, 32'h0000_3f3f, 32'h0000_2a00, "simd flags");
        `CHK("pin", 1'b1, err_n)
        `CHK("irq", 1'b1, irq)
        wr(4'h8, 32'h0000_0004, 2'b00);
        cyc(2);
        `CHK("irq", 1'b0, irq)
        for (i = 0; i < 4; i++)
        begin
            f = $random(seed) | 1;
            core(1'b0, FER_KIND_WAIT, 1'b0, f[5:0]);
            flags |= f[5:0];
        end
        cyc(3);
        rd(4'h4, 32'h0000_00ff, flags, "masked flags");
        `CHK("pin", 1'b1, err_n)
        wr(4'h0, 32'h0000_0000, 2'b00);
        cyc(3);
        `CHK("pin", 1'b0, err_n)
        `CHK("irq", 1'b1, irq)
        core(1'b1, FER_KIND_WAIT, 1'b0, 6'h00);
        cyc(20);
        `CHK("freeze", 1'b1, freeze_out)
        rd(4'h4, 32'h0000_00ff, flags | 32'hc0, "status");
        pulse_other();
        cyc(8);
        `CHK("freeze", 1'b0, freeze_out)
        wr(4'h8, 32'h0000_0002, 2'b00);
        ist = 1;
        @(posedge sys_clk);
        en <= 1'b1;
        core(1'b1, FER_KIND_WAIT, 1'b0, 6'h00);
        cyc(10);
        `CHK("freeze", 1'b0, freeze_out)
        rd(4'h8, 32'hffff_ffff, ist | 2, "int_status");
        // handler order: controller request first, then the unit's flags
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 1'b0;
        core(1'b1, FER_KIND_CLEAR, 1'b0, 6'h00);
        cyc(3);
        `CHK("pin", 1'b1, err_n)
        rd(4'h4, 32'h0000_00ff, 32'h0000_0000, "cleared flags");
        wr(4'h8, 32'h0000_000f, 2'b00);
        cyc(2);
        `CHK("irq", 1'b0, irq)
        @(posedge sys_clk);
        ign_n <= 1'b0;
        core(1'b0, FER_KIND_WAIT, 1'b0, 6'h01);
        cyc(6);
        core(1'b1, FER_KIND_WAIT, 1'b0, 6'h00);
        cyc(6);
        `CHK("freeze", 1'b0, freeze_out)
        rd(4'h8, 32'hffff_ffff, 32'h0000_0009, "int_status");
        @(posedge sys_clk);
        ign_n <= 1'b1;
        wr(4'h0, 32'h0000_003f, 2'b00);
        flags = 1;
        for (i = 0; i < 8; i++)
        begin
            f = $random(seed);
            core(1'b1, ks[i], 1'b0, f[5:0]);
            cyc(2);
            if (ks[i] inside {FER_KIND_RESTORE, FER_KIND_LOADENV})
                flags = f[5:0];
            else if (!(ks[i] inside {FER_KIND_WAIT, FER_KIND_NOWAIT}))
                flags = 0;
            rd(4'h4, 32'h0000_003f, flags, "flags");
        end
        // deferred reporting: pin waits for the next waiting instruction
        @(posedge sys_clk);
        clr <= 1'b1;
        wr(4'h0, 32'h0000_0200, 2'b00);
        clr <= 1'b0;
        core(1'b0, FER_KIND_WAIT, 1'b0, 6'h04);
        cyc(3);
        `CHK("pin", 1'b1, err_n)
        core(1'b1, FER_KIND_WAIT, 1'b0, 6'h00);
        cyc(12);
        `CHK("pin", 1'b0, err_n)
        `CHK("freeze", 1'b0, freeze_out)
        // native mode: a one-cycle fault instead of pin and freeze
        wr(4'h0, 32'h0000_0100, 2'b00);
        core(1'b1, FER_KIND_WAIT, 1'b0, 6'h00);
        @(negedge sys_clk);
        `CHK("fault", 1'b1, nf)
        `CHK("pin", 1'b1, err_n)
        `CHK("freeze", 1'b0, freeze_out)
        conclude();
    end
endmodule : fer_top_bench
`default_nettype wire
